// ==== core/frp_defs.svh ====
// Purpose: Offsets, field positions, reset values and fixed values.
// Assumes: Included by the package and the protection core.
// Notes:   Definitions only.
`ifndef FRP_DEFS_SVH
`define FRP_DEFS_SVH
`define FRP_OFF_CMD      8'h00
`define FRP_OFF_STAT     8'h04
`define FRP_OFF_STORE    8'h08
`define FRP_CMD_VAL_LSB  0
`define FRP_CMD_OP_LSB   16
`define FRP_STAT_ACTIVE  0
`define FRP_STAT_LOCK    1
`define FRP_STAT_REJ     2
`define FRP_STAT_PEND    3
`define FRP_RST_BLOCK    16'h0000
`define FRP_BLOCKED_BYTE 8'hff
`define FRP_BLK_SHIFT    11
`endif

// ==== core/frp_pkg.sv ====
// Purpose: Types shared by the read protection core.
// Assumes: Block numbers never exceed sixteen bits.
// Notes:   Timing-free block, so no time constants here.
`include "frp_defs.svh"
package frp_pkg;
    typedef logic [15:0] frp_blk_t;

    // Configuration commands, Gray ordered along the usual flow.
    typedef enum logic [1:0] {
        FRP_CMD_START = 2'h0,
        FRP_CMD_END   = 2'h1,
        FRP_CMD_LOCK  = 2'h3,
        FRP_CMD_REL   = 2'h2
    } frp_cmd_e;

    // One copy of the protection settings.
    typedef struct packed {
        frp_blk_t first;
        frp_blk_t last;
        logic     has_first;
        logic     has_last;
        logic     lock;
    } frp_cfg_s;

    // Whole state of the core.
    typedef struct packed {
        frp_cfg_s    store;
        frp_cfg_s    act;
        logic        pend;
        logic        rej;
        logic [2:0]  tgl_sync;
        logic [17:0] pd_s1;
        logic [17:0] pd_s2;
        logic        prog_ack;
        logic        prog_rej;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        rd_valid;
        logic [7:0]  rd_data;
    } frp_state_s;
endpackage

// ==== core/frp_core.sv ====
// Purpose: Flash read protection over a range of blocks, with settings
//          from an external programmer or from self-programming (APB).
// Assumes: Programmer pins are asynchronous; flash read port, blank and
//          prohibit flags come from logic on sys_clk.
// Notes:   Stored settings survive srst; only nvm_clr or a programmer release wipes them.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "frp_defs.svh"

// Operation
// - Start, end and lock can be set both by the programmer pins and by self-programming over APB.
// - While locked, any change of the start block is refused.
// - While locked, any change of the end block is refused from either path.
// - Only the programmer path can release the lock; self-programming cannot.
// - A release returns the stored start and end blocks to their unprotected values.
// - A release is accepted only with erase and boot rewrite allowed and code and data flash blank.
// - The stored settings cannot be read back over any path.
// - A read inside the protected range returns FFH instead of flash data.
// - Debugger reads are blocked in the protected range as well.
// - New settings take effect only after a reset is asserted and released.
module frp_core
    import frp_pkg::*;
#(
    parameter int ADDR_W    = 20,
    parameter int BLK_SHIFT = `FRP_BLK_SHIFT
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              nvm_clr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              prog_req_tgl,
    input  wire logic [1:0]        prog_cmd,
    input  wire logic [15:0]       prog_value,
    output logic                   prog_ack_tgl,
    output logic                   prog_rejected,
    input  wire logic              erase_prohibit,
    input  wire logic              boot_prohibit,
    input  wire logic              code_blank,
    input  wire logic              data_blank,
    input  wire logic              rd_req,
    input  wire logic              rd_dbg,
    input  wire logic [ADDR_W-1:0] rd_addr,
    input  wire logic [7:0]        flash_data,
    output logic                   rd_valid,
    output logic [7:0]             rd_data,
    output logic                   prot_active
);
    // Block number must fit the sixteen-bit setting fields.
    if (ADDR_W - BLK_SHIFT > 16 || BLK_SHIFT < 1 || ADDR_W <= BLK_SHIFT) begin
        $error("frp_core: unsupported ADDR_W or BLK_SHIFT");
    end

    localparam frp_cfg_s CFG_RST = '{
        first: `FRP_RST_BLOCK, last: `FRP_RST_BLOCK,
        has_first: 1'b0, has_last: 1'b0, lock: 1'b0};

    frp_state_s st;
    frp_state_s next_st;
    logic       rel_ok;
    logic       prog_go;
    logic       sp_go;
    logic       prog_ok;
    logic       sp_ok;
    logic       do_rel;
    logic       in_range;
    logic       setup;
    frp_blk_t   rd_blk;
    frp_cfg_s   cfg_p;
    frp_cfg_s   cfg_s;
    frp_cmd_e   sp_cmd;

    // Apply one command to a settings copy and report whether it took.
    function automatic frp_cfg_s apply_cmd(
        input  frp_cfg_s c,
        input  frp_cmd_e cmd,
        input  frp_blk_t v,
        input  logic     from_prog,
        input  logic     rel_allowed,
        output logic     ok
    );
        frp_cfg_s n;
        n  = c;
        ok = 1'b1;
        unique case (cmd)
            FRP_CMD_START: begin
                if (c.lock) begin
                    ok = 1'b0;
                end else begin
                    n.first     = v;
                    n.has_first = 1'b1;
                end
            end
            FRP_CMD_END: begin
                if (c.lock) begin
                    ok = 1'b0;
                end else begin
                    n.last     = v;
                    n.has_last = 1'b1;
                end
            end
            FRP_CMD_LOCK: begin
                n.lock = 1'b1;
            end
            FRP_CMD_REL: begin
                // Self-programming can never unlock; a release wipes range.
                if (from_prog && c.lock && rel_allowed) begin
                    n = CFG_RST;
                end else begin
                    ok = 1'b0;
                end
            end
        endcase
        return n;
    endfunction

    // Release needs every flash guard open and both areas blank.
    assign rel_ok = !erase_prohibit && !boot_prohibit
                    && code_blank && data_blank;

    // Programmer request arrives as a toggle after two sync stages.
    assign prog_go = st.tgl_sync[1] ^ st.tgl_sync[2];
    assign setup   = psel && !penable;
    assign sp_go   = setup && pwrite && (paddr == `FRP_OFF_CMD);
    assign sp_cmd  = frp_cmd_e'(pwdata[`FRP_CMD_OP_LSB +: 2]);

    // Programmer first, then self-programming on its result.
    always_comb begin
        cfg_p = apply_cmd(st.store, frp_cmd_e'(st.pd_s2[17:16]),
                          st.pd_s2[15:0], 1'b1, rel_ok, prog_ok);
        if (!prog_go) begin
            cfg_p   = st.store;
            prog_ok = 1'b0;
        end
        cfg_s = apply_cmd(cfg_p, sp_cmd,
                          pwdata[`FRP_CMD_VAL_LSB +: 16], 1'b0, rel_ok,
                          sp_ok);
        if (!sp_go) begin
            cfg_s = cfg_p;
            sp_ok = 1'b0;
        end
    end

    assign do_rel = prog_go && prog_ok
                    && (frp_cmd_e'(st.pd_s2[17:16]) == FRP_CMD_REL);

    // Only a range given both ends is enforced, inclusive at both ends.
    assign rd_blk   = frp_blk_t'(rd_addr >> BLK_SHIFT);
    assign in_range = st.act.has_first && st.act.has_last
                      && (rd_blk >= st.act.first)
                      && (rd_blk <= st.act.last);

    // Next-state logic for the whole core.
    always_comb begin
        next_st          = st;
        next_st.tgl_sync = {st.tgl_sync[1:0], prog_req_tgl};
        next_st.pd_s1    = {prog_cmd, prog_value};
        next_st.pd_s2    = st.pd_s1;
        next_st.store    = cfg_s;
        // A stored change waits for the next reset to become active.
        if ((prog_go && prog_ok) || (sp_go && sp_ok)) begin
            next_st.pend = 1'b1;
        end
        if (prog_go) begin
            next_st.prog_ack = !st.prog_ack;
            next_st.prog_rej = !prog_ok;
        end
        // Write one to clear, but a refusal in the same cycle wins.
        if (setup && pwrite && paddr == `FRP_OFF_STAT
            && pwdata[`FRP_STAT_REJ]) begin
            next_st.rej = 1'b0;
        end
        if (sp_go && !sp_ok) begin
            next_st.rej = 1'b1;
        end
        // Zero-wait APB: answer in the first access cycle.
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;
        if (setup) begin
            unique case (paddr)
                `FRP_OFF_CMD: begin
                end
                `FRP_OFF_STAT: begin
                    if (!pwrite) begin
                        next_st.prdata[`FRP_STAT_ACTIVE] =
                            st.act.has_first && st.act.has_last;
                        next_st.prdata[`FRP_STAT_LOCK] = st.act.lock;
                        next_st.prdata[`FRP_STAT_REJ]  = st.rej;
                        next_st.prdata[`FRP_STAT_PEND] = st.pend;
                    end
                end
                `FRP_OFF_STORE: begin
                    // Extra area window: always zero, never the settings.
                    next_st.prdata = 32'h0000_0000;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        // Flash read path, debugger reads treated the same.
        next_st.rd_valid = rd_req;
        next_st.rd_data  = 8'h00;
        if (rd_req) begin
            next_st.rd_data = in_range ? `FRP_BLOCKED_BYTE
                                       : flash_data;
        end
        // Chip reset keeps the store and loads it into the active copy.
        if (srst) begin
            next_st          = '0;
            next_st.store    = st.store;
            next_st.act      = st.store;
            next_st.prog_ack = st.prog_ack;
            next_st.tgl_sync = {3{prog_req_tgl}};
        end
        // Blanking must not leave a stale sync value that fakes a toggle.
        if (nvm_clr) begin
            next_st          = '0;
            next_st.store    = CFG_RST;
            next_st.act      = CFG_RST;
            next_st.tgl_sync = {3{prog_req_tgl}};
        end
    end

    // Single state register.
    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // Outputs straight from flops, except prot_active, an AND of two active-copy flops.
    assign pready        = st.pready;
    assign prdata        = st.prdata;
    assign pslverr       = st.pslverr;
    assign prog_ack_tgl  = st.prog_ack;
    assign prog_rejected = st.prog_rej;
    assign rd_valid      = st.rd_valid;
    assign rd_data       = st.rd_data;
    assign prot_active   = st.act.has_first && st.act.has_last;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst || nvm_clr);

    property p_lock_first;
        st.store.lock && !do_rel |=> $stable(st.store.first);
    endproperty
    a_lock_first: assert property (p_lock_first)
        else $error("start block changed while locked");

    property p_lock_last;
        st.store.lock && !do_rel |=> $stable(st.store.last);
    endproperty
    a_lock_last: assert property (p_lock_last)
        else $error("end block changed while locked");

    property p_sp_no_release;
        sp_go && sp_cmd == FRP_CMD_REL && st.store.lock && !do_rel
            |=> st.store.lock && st.rej;
    endproperty
    a_sp_no_release: assert property (p_sp_no_release)
        else $error("self-programming released the lock");

    property p_release_clears;
        do_rel && !sp_go |=> st.store == CFG_RST;
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("release did not reset the range");

    property p_release_guard;
        do_rel |-> !erase_prohibit && !boot_prohibit
                   && code_blank && data_blank;
    endproperty
    a_release_guard: assert property (p_release_guard)
        else $error("release accepted against a guard");

    property p_store_unreadable;
        setup && !pwrite && paddr == `FRP_OFF_STORE
            |=> pready && prdata == 32'h0000_0000;
    endproperty
    a_store_unreadable: assert property (p_store_unreadable)
        else $error("stored settings visible on read");

    property p_blocked_read;
        rd_req && in_range |=> rd_valid && rd_data == `FRP_BLOCKED_BYTE;
    endproperty
    a_blocked_read: assert property (p_blocked_read)
        else $error("protected byte leaked");

    property p_dbg_blocked;
        rd_req && rd_dbg && in_range ##1 !srst |-> rd_data == 8'hff;
    endproperty
    a_dbg_blocked: assert property (p_dbg_blocked)
        else $error("debugger read a protected byte");

    property p_no_early_effect;
        !srst ##1 !srst |-> $stable(st.act);
    endproperty
    a_no_early_effect: assert property (p_no_early_effect)
        else $error("settings took effect without reset");

    property p_outside_reads;
        rd_req && !in_range |=> rd_data == $past(flash_data);
    endproperty
    a_outside_reads: assert property (p_outside_reads)
        else $error("unprotected read altered");

    property p_lock_held;
        st.store.lock && !do_rel |=> st.store.lock;
    endproperty
    a_lock_held: assert property (p_lock_held)
        else $error("lock dropped without a programmer release");

    property p_pend_set;
        (prog_go && prog_ok) || (sp_go && sp_ok) |=> st.pend;
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("accepted change not marked pending");

    property p_refusal_sticky;
        sp_go && !sp_ok |=> st.rej;
    endproperty
    a_refusal_sticky: assert property (p_refusal_sticky)
        else $error("refused command left no sticky flag");

    // The answer stands one cycle, so a held pready would double a transfer.
    property p_apb_pulse;
        pready |=> !pready && !pslverr;
    endproperty
    a_apb_pulse: assert property (p_apb_pulse)
        else $error("bus answer held longer than one cycle");

    c_block_hit: cover property (rd_req && in_range);
    c_lock_set: cover property (sp_go && sp_cmd == FRP_CMD_LOCK);
    c_release: cover property (do_rel);
    c_sp_refused: cover property (sp_go && !sp_ok);
    c_locked_read: cover property (rd_req && in_range && st.act.lock);
endmodule

// ==== dv/frp_prog_model.sv ====
// Purpose: Model of the external programmer that drives the pin port.
// Assumes: One command at a time; the next waits for the acknowledge.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/10ps
module frp_prog_model
    import frp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        prog_ack_tgl,
    input  wire logic        prog_rejected,
    output logic             prog_req_tgl,
    output logic [1:0]       prog_cmd,
    output logic [15:0]      prog_value
);
    // Quiet lines until the first command.
    initial begin
        prog_req_tgl = 1'b0;
        prog_cmd     = 2'h0;
        prog_value   = 16'h0000;
    end

    // Setup is held three clocks before the toggle, since the core
    // sees these pins only through two synchronising flops.
    task automatic send(input frp_cmd_e c, input frp_blk_t v,
                        output logic rej);
        logic a0;
        int   n;
        a0 = prog_ack_tgl;
        n = 0;
        @(posedge sys_clk);
        prog_cmd <= c;
        prog_value <= v;
        repeat (3) @(posedge sys_clk);
        prog_req_tgl <= ~prog_req_tgl;
        do begin
            @(posedge sys_clk);
            n++;
        end while (prog_ack_tgl === a0 && n < 20);
        rej = (n < 20) ? prog_rejected : 1'bx;
        prog_cmd <= ~c;
        prog_value <= ~v;
    endtask
endmodule

// ==== dv/frp_core_tb.sv ====
// Purpose: Self-checking bench for the read protection core.
// Assumes: BLK_SHIFT 11 and ADDR_W 20, so a block is 2 KiB.
// Notes:   Read results are queued by the driver, checked by a monitor.
`timescale 1ns/10ps
`include "frp_defs.svh"
module frp_core_tb
    import frp_pkg::*;
;
    logic        sys_clk, srst, nvm_clr, psel, penable, pwrite, pready;
    logic        pslverr, prog_req_tgl, prog_ack_tgl, prog_rejected;
    logic        erase_prohibit, boot_prohibit, code_blank, data_blank;
    logic        rd_req, rd_dbg, rd_valid, prot_active, e, r;
    logic [7:0]  paddr, flash_data, rd_data;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  prog_cmd;
    logic [15:0] prog_value;
    logic [19:0] rd_addr;
    logic [31:0] seed = 32'h4748b3f7;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    // Highest block of the boot clusters; an assumed size for this bench.
    localparam int BOOT_LAST_BLK = 3;

    frp_core i_frp_core (.sys_clk, .srst, .nvm_clr, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .prog_req_tgl, .prog_cmd, .prog_value, .prog_ack_tgl,
        .prog_rejected, .erase_prohibit, .boot_prohibit, .code_blank,
        .data_blank, .rd_req, .rd_dbg, .rd_addr, .flash_data, .rd_valid,
        .rd_data, .prot_active);
    frp_prog_model i_frp_prog_model (.sys_clk, .prog_ack_tgl,
        .prog_rejected, .prog_req_tgl, .prog_cmd, .prog_value);

    // Clock at 20 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string w, input logic [31:0] x, g);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never sees pready.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input frp_cmd_e c, input logic [15:0] v);
        apb(1'b1, `FRP_OFF_CMD, {14'h0, c, v});
    endtask

    task automatic stat(input logic [3:0] m, input logic [3:0] x);
        apb(1'b0, `FRP_OFF_STAT, 32'h0);
        chk("status", {28'h0, x & m}, {28'h0, q[3:0] & m});
    endtask

    // A refused self-programming command raises the sticky bit (W1C).
    task automatic refused(input frp_cmd_e c, input logic [15:0] v);
        cmd(c, v);
        stat(4'h4, 4'h4);
        apb(1'b1, `FRP_OFF_STAT, 32'h4);
        stat(4'h4, 4'h0);
    endtask

    task automatic rd(input logic [15:0] b, input logic dbg, input logic p);
        logic [7:0] fd;
        fd = 8'(rnd());
        @(posedge sys_clk);
        rd_req <= 1'b1;
        rd_dbg <= dbg;
        rd_addr <= {b[8:0], 11'(rnd())};
        flash_data <= fd;
        exp_q.push_back(p ? `FRP_BLOCKED_BYTE : fd);
        @(posedge sys_clk);
        rd_req <= 1'b0;
        flash_data <= ~fd;
    endtask

    // Reads the blocks around a range, debugger on odd blocks.
    task automatic span(input int lo, input int hi, input logic on);
        for (int b = lo - 1; b <= hi + 1; b++)
            rd(16'(b), b[0], on && b >= lo && b <= hi);
    endtask

    task automatic do_reset(input int n);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (n) @(posedge sys_clk);
        srst <= 1'b0;
    endtask

    // Each read result is taken against the oldest queued note.
    always @(posedge sys_clk) begin
        // A result with no note left over is a mismatch by itself.
        if (rd_valid === 1'b1 && exp_q.size() == 0)
            chk("rd_extra", 32'h0, 32'h1);
        else if (rd_valid === 1'b1)
            chk("rd_data", 32'(exp_q.pop_front()), 32'(rd_data));
    end

    // Hang guard, far above the few hundred cycles the run needs.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        {srst, nvm_clr, psel, penable, pwrite, paddr, pwdata} = '1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {erase_prohibit, boot_prohibit, code_blank, data_blank} = 4'h3;
        {rd_req, rd_dbg, rd_addr, flash_data} = '0;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        nvm_clr <= 1'b0;
        span(2, 3, 1'b0);
        cmd(FRP_CMD_START, 16'h4);
        cmd(FRP_CMD_END, 16'h6);
        stat(4'h9, 4'h8);
        span(4, 6, 1'b0);
        do_reset(1);
        stat(4'hb, 4'h1);
        chk("prot_active", 32'h1, {31'h0, prot_active});
        span(4, 6, 1'b1);
        apb(1'b0, `FRP_OFF_STORE, 32'h0);
        chk("store", 32'h0, q);
        apb(1'b0, `FRP_OFF_CMD, 32'h0);
        chk("cmd_rd", 32'h0, q);
        apb(1'b0, 8'h0c, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        // A range that reaches a boot cluster comes with the boot lock.
        boot_prohibit <= (9 <= BOOT_LAST_BLK);
        i_frp_prog_model.send(FRP_CMD_START, 16'h9, r);
        chk("p_start", 32'h0, {31'h0, r});
        i_frp_prog_model.send(FRP_CMD_END, 16'ha, r);
        chk("p_end", 32'h0, {31'h0, r});
        cmd(FRP_CMD_LOCK, 16'h0);
        do_reset(2);
        stat(4'h3, 4'h3);
        span(9, 10, 1'b1);
        refused(FRP_CMD_START, 16'h1);
        refused(FRP_CMD_END, 16'hc);
        refused(FRP_CMD_REL, 16'h0);
        i_frp_prog_model.send(FRP_CMD_END, 16'hc, r);
        chk("p_end_lk", 32'h1, {31'h0, r});
        for (int i = 0; i < 4; i++) begin
            {erase_prohibit, boot_prohibit, code_blank, data_blank} <=
                4'h3 ^ 4'(1 << i);
            i_frp_prog_model.send(FRP_CMD_REL, 16'h0, r);
            chk("p_rel_bad", 32'h1, {31'h0, r});
        end
        {erase_prohibit, boot_prohibit, code_blank, data_blank} <= 4'h3;
        i_frp_prog_model.send(FRP_CMD_REL, 16'h0, r);
        chk("p_rel", 32'h0, {31'h0, r});
        do_reset(1);
        stat(4'h3, 4'h0);
        chk("prot_active", 32'h0, {31'h0, prot_active});
        span(9, 10, 1'b0);
        repeat (3) @(posedge sys_clk);
        chk("rd_left", 32'h0, 32'(exp_q.size()));
        complete_run();
    end
endmodule
